// >>> shared/rst_ctrl_pkg.sv
// Constants and types shared by the reset controller
package rst_ctrl_pkg;
  // Reset cause encoding, one bit per source
  localparam int NUM_SRC      = 10;
  localparam int SRC_POR      = 0;
  localparam int SRC_PIN      = 1;
  localparam int SRC_CMP      = 2;
  localparam int SRC_SW       = 3;
  localparam int SRC_SUPPLY   = 4;
  localparam int SRC_WDOG     = 5;
  localparam int SRC_MCLK     = 6;
  localparam int SRC_FLASH    = 7;
  localparam int SRC_WAKE     = 8;
  localparam int SRC_OSCFAIL  = 9;
  // Widths and values forced at reset
  localparam int PORT_W       = 24;
  localparam int PC_W         = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] CLK_SEL_INTERNAL = 2'h0;
  localparam logic [2:0] WDOG_TMO_MAX = 3'h7;
  // Hold time in reset after all requests drop
  localparam int HOLD_NS      = 100;
  localparam int CLK_NS       = 25;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_W       = 4;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_RELEASE
  } rst_state_t;
endpackage

// >>> shared/rst_src_if.sv
// Bundle of captured reset requests between sequencer and cause logger
`timescale 1ns/1ps
interface rst_src_if;
  logic [rst_ctrl_pkg::NUM_SRC-1:0] req;
  logic                             enter;
  modport ctrl (output req, output enter);
  modport log  (input req, input enter);
endinterface

// >>> rtl/rst_cause_log.sv
// Records the source of the most recent reset
`timescale 1ns/1ps
module rst_cause_log (
  input  wire logic                             i_mclk,
  input  wire logic                             i_por_n,
  rst_src_if.log                                src,
  output logic [rst_ctrl_pkg::NUM_SRC-1:0]      o_cause
);
  logic [rst_ctrl_pkg::NUM_SRC-1:0] cause_q;
  logic [rst_ctrl_pkg::NUM_SRC-1:0] cause_d;

  // Latch all requesting sources on reset entry
  always_comb begin
    cause_d = cause_q;
    if (src.enter) begin
      cause_d = src.req;
    end
  end

  // Cause survives all but power-on
  always_ff @(posedge i_mclk) begin
    if (!i_por_n) begin
      cause_q <= '0;
      cause_q[rst_ctrl_pkg::SRC_POR] <= 1'b1;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign o_cause = cause_q;
endmodule

// >>> rtl/system_reset_controller.sv
// Reset sequencer: gathers requests, holds core, forces reset state
`timescale 1ns/1ps
// Contract
// - While in reset the core is stalled and fetches no instruction.
// - Module registers take reset values, power-on-only bits are kept.
// - Port pins go to a known predefined state on reset entry.
// - All interrupt sources and timers are disabled on reset entry.
// - RAM is never written or cleared by a reset.
// - Port latches are set to 1 and outputs made open-drain.
// - Weak pull-ups are on during reset and after leaving it.
// - Power-on and supply-monitor resets drive the reset pin low.
// - The program counter is cleared to 0x0000 on leaving reset.
// - The internal oscillator is selected as system clock on exit.
// - The watchdog is enabled on exit without software action.
// - Reset is entered on any of the ten listed request sources.
// - Watchdog overflow resets the device and leaves the pin undriven.
// - After reset the watchdog runs with its longest timeout.
module system_reset_controller #(
  parameter int PORT_W = rst_ctrl_pkg::PORT_W
) (
  input  wire logic                             i_mclk,
  input  wire logic                             i_rst_n,
  input  wire logic                             i_supply_low,
  input  wire logic                             i_reset_pin_n_in,
  input  wire logic                             i_cmp_rst,
  input  wire logic                             i_sw_rst,
  input  wire logic                             i_watchdog_timer_ovf,
  input  wire logic                             i_missing_clk,
  input  wire logic                             i_flash_err,
  input  wire logic                             i_wake_timer_unit_alarm,
  input  wire logic                             i_wake_timer_unit_oscfail,
  output logic                                  o_reset_pin_n_out,
  output logic                                  o_reset_pin_n_oe_n,
  output logic                                  o_sys_rst_n,
  output logic                                  o_core_halt,
  output logic                                  o_ram_we_block,
  output logic [PORT_W-1:0]                     o_port_latch,
  output logic [PORT_W-1:0]                     o_port_open_drain,
  output logic                                  o_weak_pullup_en,
  output logic                                  o_irq_disable,
  output logic                                  o_timer_disable,
  output logic                                  o_pc_load,
  output logic [rst_ctrl_pkg::PC_W-1:0]         o_program_counter,
  output logic [1:0]                            o_clk_sel,
  output logic                                  o_watchdog_timer_en,
  output logic [2:0]                            o_watchdog_timer_tmo,
  output logic [rst_ctrl_pkg::NUM_SRC-1:0]      o_reset_cause
);
  rst_src_if src ();

  logic [rst_ctrl_pkg::NUM_SRC-1:0] req;
  logic [rst_ctrl_pkg::NUM_SRC-1:0] req_lat_q;
  logic [rst_ctrl_pkg::NUM_SRC-1:0] req_lat_d;
  rst_ctrl_pkg::rst_state_t         state_q;
  rst_ctrl_pkg::rst_state_t         state_d;
  logic [rst_ctrl_pkg::HOLD_W-1:0]  hold_q;
  logic [rst_ctrl_pkg::HOLD_W-1:0]  hold_d;
  logic                             drive_pin_q;
  logic                             drive_pin_d;
  logic                             in_rst_q;
  logic                             in_rst_d;
  logic                             pc_load_q;
  logic                             pc_load_d;
  logic [rst_ctrl_pkg::NUM_SRC-1:0] cause;
  logic                             any_req;
  logic                             enter;

  // Gather requests; pin is excluded while we drive it ourselves
  always_comb begin
    req = '0;
    req[rst_ctrl_pkg::SRC_POR]     = !i_rst_n;
    req[rst_ctrl_pkg::SRC_PIN]     = !i_reset_pin_n_in && !drive_pin_q;
    req[rst_ctrl_pkg::SRC_CMP]     = i_cmp_rst;
    req[rst_ctrl_pkg::SRC_SW]      = i_sw_rst;
    req[rst_ctrl_pkg::SRC_SUPPLY]  = i_supply_low;
    req[rst_ctrl_pkg::SRC_WDOG]    = i_watchdog_timer_ovf;
    req[rst_ctrl_pkg::SRC_MCLK]    = i_missing_clk;
    req[rst_ctrl_pkg::SRC_FLASH]   = i_flash_err;
    req[rst_ctrl_pkg::SRC_WAKE]    = i_wake_timer_unit_alarm;
    req[rst_ctrl_pkg::SRC_OSCFAIL] = i_wake_timer_unit_oscfail;
    any_req = |req;
  end

  assign enter = any_req && (state_q == rst_ctrl_pkg::ST_RUN);
  assign src.req = req_lat_d;
  assign src.enter = enter;

  // Sequencer: hold while any request, then a fixed hold time
  always_comb begin
    state_d     = state_q;
    hold_d      = hold_q;
    req_lat_d   = req_lat_q;
    drive_pin_d = drive_pin_q;
    in_rst_d    = in_rst_q;
    pc_load_d   = 1'b0;
    if (enter) begin
      req_lat_d = req;
    end else if (state_q != rst_ctrl_pkg::ST_RUN) begin
      req_lat_d = req_lat_q | req;
    end
    case (state_q)
      rst_ctrl_pkg::ST_RUN: begin
        if (any_req) begin
          state_d  = rst_ctrl_pkg::ST_HOLD;
          in_rst_d = 1'b1;
          hold_d   = rst_ctrl_pkg::HOLD_W'(rst_ctrl_pkg::HOLD_CYC);
          drive_pin_d = req[rst_ctrl_pkg::SRC_POR] ||
                        req[rst_ctrl_pkg::SRC_SUPPLY];
        end
      end
      rst_ctrl_pkg::ST_HOLD: begin
        if (req[rst_ctrl_pkg::SRC_POR] || req[rst_ctrl_pkg::SRC_SUPPLY]) begin
          drive_pin_d = 1'b1;
        end
        if (any_req) begin
          hold_d = rst_ctrl_pkg::HOLD_W'(rst_ctrl_pkg::HOLD_CYC);
        end else if (hold_q > 1) begin
          hold_d = hold_q - 1'b1;
        end else begin
          state_d = rst_ctrl_pkg::ST_RELEASE;
        end
      end
      rst_ctrl_pkg::ST_RELEASE: begin
        if (any_req) begin
          // A late request must not slip through the release cycle
          state_d = rst_ctrl_pkg::ST_HOLD;
          hold_d  = rst_ctrl_pkg::HOLD_W'(rst_ctrl_pkg::HOLD_CYC);
          drive_pin_d = drive_pin_q || req[rst_ctrl_pkg::SRC_POR] ||
                        req[rst_ctrl_pkg::SRC_SUPPLY];
        end else begin
          // All outputs leave reset on this one edge
          state_d     = rst_ctrl_pkg::ST_RUN;
          in_rst_d    = 1'b0;
          drive_pin_d = 1'b0;
          pc_load_d   = 1'b1;
        end
      end
      default: begin
        state_d = rst_ctrl_pkg::ST_HOLD;
      end
    endcase
  end

  // Sequencer registers; power-on forces reset state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q     <= rst_ctrl_pkg::ST_HOLD;
      hold_q      <= rst_ctrl_pkg::HOLD_W'(rst_ctrl_pkg::HOLD_CYC);
      req_lat_q   <= '0;
      drive_pin_q <= 1'b1;
      in_rst_q    <= 1'b1;
      pc_load_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      hold_q      <= hold_d;
      req_lat_q   <= req_lat_d;
      drive_pin_q <= drive_pin_d;
      in_rst_q    <= in_rst_d;
      pc_load_q   <= pc_load_d;
    end
  end

  // Reset cause kept across non-power-on resets
  rst_cause_log u_log (
    .i_mclk  (i_mclk),
    .i_por_n (i_rst_n),
    .src     (src),
    .o_cause (cause)
  );

  // Registered outputs derived from the sequencer state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_reset_pin_n_out    <= 1'b0;
      o_reset_pin_n_oe_n   <= 1'b0;
      o_sys_rst_n          <= 1'b0;
      o_core_halt          <= 1'b1;
      o_ram_we_block       <= 1'b1;
      o_port_latch         <= '1;
      o_port_open_drain    <= '1;
      o_weak_pullup_en     <= 1'b1;
      o_irq_disable        <= 1'b1;
      o_timer_disable      <= 1'b1;
      o_pc_load            <= 1'b0;
      o_program_counter    <= rst_ctrl_pkg::PC_RESET;
      o_clk_sel            <= rst_ctrl_pkg::CLK_SEL_INTERNAL;
      o_watchdog_timer_en  <= 1'b0;
      o_watchdog_timer_tmo <= rst_ctrl_pkg::WDOG_TMO_MAX;
      o_reset_cause        <= '0;
    end else begin
      o_reset_pin_n_out    <= 1'b0;
      o_reset_pin_n_oe_n   <= !drive_pin_d;
      o_sys_rst_n          <= !in_rst_d;
      o_core_halt          <= in_rst_d;
      o_ram_we_block       <= in_rst_d;
      if (in_rst_d) begin
        o_port_latch      <= '1;
        o_port_open_drain <= '1;
      end
      o_weak_pullup_en     <= 1'b1;
      o_irq_disable        <= in_rst_d;
      o_timer_disable      <= in_rst_d;
      o_pc_load            <= pc_load_d;
      o_program_counter    <= rst_ctrl_pkg::PC_RESET;
      o_clk_sel            <= rst_ctrl_pkg::CLK_SEL_INTERNAL;
      o_watchdog_timer_en  <= !in_rst_d;
      o_watchdog_timer_tmo <= rst_ctrl_pkg::WDOG_TMO_MAX;
      o_reset_cause        <= cause;
    end
  end
endmodule

// >>> tb/rst_pin_model.sv
// External reset pin with pull-up, a push button and open-drain drive
`timescale 1ns/1ps
module rst_pin_model (
  input  wire logic i_press,
  input  wire logic i_drv_out,
  input  wire logic i_drv_oe_n,
  output logic      o_pin
);
  // Low when button pressed or device pulls down, else pull-up level
  assign o_pin = (i_press || (!i_drv_oe_n && !i_drv_out)) ? 1'b0 : 1'b1;
endmodule

// >>> tb/rst_ctrl_checker.sv
// Concurrent checks on the reset controller ports
`timescale 1ns/1ps
module rst_ctrl_checker #(
  parameter int PORT_W = rst_ctrl_pkg::PORT_W
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_supply_low,
  input  wire logic              i_reset_pin_n_in,
  input  wire logic              i_cmp_rst,
  input  wire logic              i_sw_rst,
  input  wire logic              i_watchdog_timer_ovf,
  input  wire logic              i_missing_clk,
  input  wire logic              i_flash_err,
  input  wire logic              i_wake_timer_unit_alarm,
  input  wire logic              i_wake_timer_unit_oscfail,
  input  wire logic              o_reset_pin_n_oe_n,
  input  wire logic              o_sys_rst_n,
  input  wire logic              o_core_halt,
  input  wire logic              o_ram_we_block,
  input  wire logic [PORT_W-1:0] o_port_latch,
  input  wire logic [PORT_W-1:0] o_port_open_drain,
  input  wire logic              o_weak_pullup_en,
  input  wire logic              o_irq_disable,
  input  wire logic              o_timer_disable,
  input  wire logic              o_pc_load,
  input  wire logic [15:0]       o_program_counter,
  input  wire logic [1:0]        o_clk_sel,
  input  wire logic              o_watchdog_timer_en,
  input  wire logic [2:0]        o_watchdog_timer_tmo
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Any request seen, pin only while not driven by us
  logic req;
  assign req = i_supply_low || i_cmp_rst || i_sw_rst || i_watchdog_timer_ovf
    || i_missing_clk || i_flash_err || i_wake_timer_unit_alarm
    || i_wake_timer_unit_oscfail || (o_reset_pin_n_oe_n && !i_reset_pin_n_in);
  a_halt_in_reset: assert property (o_core_halt == !o_sys_rst_n)
    else $error("core halt does not follow reset");
  a_ports_forced: assert property (!o_sys_rst_n |-> &o_port_latch
    && &o_port_open_drain) else $error("ports not forced");
  a_irq_timer_off: assert property (!o_sys_rst_n |-> o_irq_disable
    && o_timer_disable && o_ram_we_block) else $error("irq or timer on");
  a_pullup_on: assert property (o_weak_pullup_en)
    else $error("pull-ups off");
  a_request_enters: assert property (req |=> !o_sys_rst_n)
    else $error("request did not enter reset");
  a_supply_drives: assert property (i_supply_low |=> !o_reset_pin_n_oe_n)
    else $error("pin not driven for supply reset");
  a_wdog_pin_free: assert property (o_sys_rst_n && i_watchdog_timer_ovf
    |=> o_reset_pin_n_oe_n) else $error("pin driven for watchdog reset");
  a_exit_state: assert property ($rose(o_sys_rst_n) |-> o_pc_load
    && o_program_counter == 16'h0000 && o_clk_sel == 2'h0)
    else $error("bad exit state");
  a_wdog_on_exit: assert property ($rose(o_sys_rst_n) |->
    o_watchdog_timer_en && o_watchdog_timer_tmo == 3'h7)
    else $error("watchdog not armed on exit");
  a_hold_release: assert property (req ##1 !req [*5] |=> o_sys_rst_n)
    else $error("release not after hold");
  c_enter: cover property (req ##1 !o_sys_rst_n);
  c_release: cover property ($rose(o_sys_rst_n));
  c_supply: cover property (i_supply_low ##1 !o_reset_pin_n_oe_n);
endmodule
bind system_reset_controller rst_ctrl_checker #(.PORT_W(PORT_W)) u_chk (.*);

// >>> tb/testbench.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module testbench;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [9:0]  req_v = 10'h000;
  wire logic   i_reset_pin_n_in;
  wire logic   i_supply_low = req_v[rst_ctrl_pkg::SRC_SUPPLY];
  wire logic   i_cmp_rst = req_v[rst_ctrl_pkg::SRC_CMP];
  wire logic   i_sw_rst = req_v[rst_ctrl_pkg::SRC_SW];
  wire logic   i_watchdog_timer_ovf = req_v[rst_ctrl_pkg::SRC_WDOG];
  wire logic   i_missing_clk = req_v[rst_ctrl_pkg::SRC_MCLK];
  wire logic   i_flash_err = req_v[rst_ctrl_pkg::SRC_FLASH];
  wire logic   i_wake_timer_unit_alarm = req_v[rst_ctrl_pkg::SRC_WAKE];
  wire logic   i_wake_timer_unit_oscfail = req_v[rst_ctrl_pkg::SRC_OSCFAIL];
  logic        o_reset_pin_n_out, o_reset_pin_n_oe_n, o_sys_rst_n;
  logic        o_core_halt, o_ram_we_block, o_weak_pullup_en;
  logic        o_irq_disable, o_timer_disable, o_pc_load, o_watchdog_timer_en;
  logic [23:0] o_port_latch, o_port_open_drain;
  logic [15:0] o_program_counter;
  logic [1:0]  o_clk_sel;
  logic [2:0]  o_watchdog_timer_tmo;
  logic [9:0]  o_reset_cause;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n;
  system_reset_controller u_dut (.*);
  rst_pin_model u_pin (.i_press(req_v[rst_ctrl_pkg::SRC_PIN]),
    .i_drv_out(o_reset_pin_n_out), .i_drv_oe_n(o_reset_pin_n_oe_n),
    .o_pin(i_reset_pin_n_in));
  // Clock at 25 ns period
  always #12.5 i_mclk = ~i_mclk;
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // One-cycle request pulse, returns at the sampling edge
  task automatic pulse(input int k);
    @(posedge i_mclk) req_v[k] <= 1'b1;
    @(posedge i_mclk) req_v[k] <= 1'b0;
  endtask
  // Edges from the sampling edge until reset lifts
  task automatic count_release(output int cnt);
    cnt = 0;
    do begin
      @(posedge i_mclk);
      #1;
      cnt++;
      if (cnt == 1) check(o_sys_rst_n === 1'b0 && o_core_halt === 1'b1 &&
        o_irq_disable === 1'b1 && &o_port_latch === 1'b1, "not in reset");
    end while (o_sys_rst_n !== 1'b1 && cnt < 50);
    check(o_pc_load === 1'b1 && o_program_counter === 16'h0000, "no start");
  endtask
  task automatic t_por;
    repeat (2) @(posedge i_mclk);
    #1 check(o_reset_pin_n_oe_n === 1'b0 && o_reset_pin_n_out === 1'b0, "pin not driven at power-on");
    count_release(n);
    check(o_reset_cause[rst_ctrl_pkg::SRC_POR] === 1'b1, "cause");
    check(o_clk_sel === 2'h0 && o_watchdog_timer_en === 1'b1, "exit");
    check(o_watchdog_timer_tmo === 3'h7, "timeout not longest");
    check(o_reset_pin_n_oe_n === 1'b1, "pin still driven");
    $display("test por done");
  endtask
  task automatic t_sources;
    for (int k = 1; k < 10; k++) begin
      pulse(k);
      count_release(n);
      check(n == rst_ctrl_pkg::HOLD_CYC + 1, "release count");
      check(o_reset_cause[k] === 1'b1, "cause bit missing");
      check(o_weak_pullup_en === 1'b1, "pull-ups off");
    end
    $display("test sources done");
  endtask
  task automatic t_retrigger;
    pulse(rst_ctrl_pkg::SRC_SW);
    @(posedge i_mclk);
    pulse(rst_ctrl_pkg::SRC_CMP);
    count_release(n);
    check(n == rst_ctrl_pkg::HOLD_CYC + 1, "hold not restarted");
    $display("test retrigger done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_por();
    t_sources();
    t_retrigger();
    test_done();
  end
  // Watchdog against a hang
  initial begin
    #50000;
    mismatches++;
    test_done();
  end
endmodule
